// ---- bcs_addr_decode.sv ----
// Address decoder that selects one register of the bank.
`timescale 1ns/1ns
`default_nettype none
module bcs_addr_decode (
	// Bus address.
	input wire logic [bcs_pkg::ADDR_W-1:0] i_addr,
	// Register selects.
	output var bcs_pkg::bcs_sel_t o_sel
);

	wire sel_cfg;
	wire sel_tb;
	wire sel_slot;

	assign sel_cfg = (i_addr == bcs_pkg::OFS_CFG_SWITCH);
	assign sel_tb = (i_addr == bcs_pkg::OFS_TIME_BASE);
	assign sel_slot = (i_addr == bcs_pkg::OFS_SLOT_ADDR);

	assign o_sel.cfg_switch = sel_cfg;
	assign o_sel.time_base = sel_tb;
	assign o_sel.slot_addr = sel_slot;
	assign o_sel.hit = sel_cfg | sel_tb | sel_slot;

endmodule : bcs_addr_decode
`default_nettype wire

// ---- bcs_board_cfg_regs.sv ----
// Board configuration switch, time-base gate and slot address register bank.
`timescale 1ns/1ns
`default_nettype none
module bcs_board_cfg_regs #(
	parameter int unsigned CFG_W = bcs_pkg::CFG_W,
	parameter int unsigned SLOT_W = bcs_pkg::SLOT_W
) (
	// Clock and reset.
	input wire logic i_ref_clk,
	input wire logic i_nrst,

	// Register port.
	input wire logic [bcs_pkg::ADDR_W-1:0] i_addr,
	input wire logic [bcs_pkg::DATA_W-1:0] i_wdata,
	input wire logic i_wr,
	input wire logic i_rd,
	output logic [bcs_pkg::DATA_W-1:0] o_rdata,
	output logic o_rd_valid,
	output logic o_unmapped,

	// Configuration switch positions, high while a position is ON.
	input wire logic [CFG_W-1:0] i_cfg_switch_on,

	// Backplane slot address pins, active low.
	input wire logic i_slot_addr_bit0_n,
	input wire logic i_slot_addr_bit1_n,
	input wire logic i_slot_addr_bit2_n,
	input wire logic i_slot_addr_bit3_n,
	input wire logic i_slot_addr_bit4_n,
	input wire logic i_slot_addr_parity_n,

	// Processor time-base enable.
	output logic o_processor_time_base_gate
);

	localparam int unsigned PIN_W = CFG_W + SLOT_W + 1;

	// Elaboration checks: the layouts below are fixed at eight data bits.
	if (CFG_W != bcs_pkg::DATA_W) begin : g_chk_cfg
		$error("bcs_board_cfg_regs needs CFG_W equal to the data width");
	end
	if (SLOT_W != bcs_pkg::SLOT_ADDR_MSB - bcs_pkg::SLOT_ADDR_LSB + 1)
	begin : g_chk_slot
		$error("bcs_board_cfg_regs needs SLOT_W to fit bits 7 to 3");
	end

	// Reverses and inverts a field, used for the slot address layout.
	function automatic logic [SLOT_W-1:0] rev_inv(
		input logic [SLOT_W-1:0] v
	);
		logic [SLOT_W-1:0] r;
		r = '0;
		for (int i = 0; i < SLOT_W; i++) begin
			r[SLOT_W-1-i] = ~v[i];
		end
		return r;
	endfunction : rev_inv

	// Bus request carrier.
	bcs_pkg::bcs_bus_req_t req;
	bcs_pkg::bcs_sel_t sel;

	assign req.addr = i_addr;
	assign req.wdata = i_wdata;
	assign req.wr = i_wr;
	assign req.rd = i_rd;

	// Pin carrier.
	bcs_pkg::bcs_slot_pins_t slot_pins;
	bcs_pkg::bcs_slot_pins_t slot_sync;

	assign slot_pins.addr_n = {
		i_slot_addr_bit4_n,
		i_slot_addr_bit3_n,
		i_slot_addr_bit2_n,
		i_slot_addr_bit1_n,
		i_slot_addr_bit0_n
	};
	assign slot_pins.parity_n = i_slot_addr_parity_n;

	// Synchronised pin levels.
	logic [PIN_W-1:0] pins_async;
	logic [PIN_W-1:0] pins_level;
	logic [CFG_W-1:0] cfg_on_sync;

	assign pins_async = {i_cfg_switch_on, slot_pins};
	assign cfg_on_sync = pins_level[PIN_W-1 -: CFG_W];
	assign slot_sync = pins_level[SLOT_W:0];

	bcs_pin_sync #(
		.WIDTH(PIN_W)
	) u_pin_sync (
		.i_ref_clk(i_ref_clk),
		.i_nrst(i_nrst),
		.i_async(pins_async),
		.o_level(pins_level)
	);

	// Register address decode.
	bcs_addr_decode u_addr_decode (
		.i_addr(req.addr),
		.o_sel(sel)
	);

	// Access qualifiers.
	wire wr_time_base;
	wire rd_any;
	wire access_any;
	wire access_miss;

	assign wr_time_base = req.wr & sel.time_base;
	assign rd_any = req.rd;
	assign access_any = req.wr | req.rd;
	assign access_miss = access_any & ~sel.hit;

	// Time-base drive bit; only bit 0 of a write at 0x6 is kept.
	logic tb_drive_reg;
	logic tb_drive_next;

	assign tb_drive_next = wr_time_base ?
		req.wdata[bcs_pkg::TB_DRIVE_BIT] : tb_drive_reg;

	// Gate pin register, loaded from the same next value as the control bit on the same edge.
	logic tb_gate_reg;
	logic tb_gate_next;

	assign tb_gate_next = tb_drive_next;

	// Read views of each register.
	wire [bcs_pkg::DATA_W-1:0] cfg_view;
	wire [bcs_pkg::DATA_W-1:0] tb_view;
	wire [bcs_pkg::DATA_W-1:0] slot_view;

	// Bit n shows position n: low while ON, high while OFF.
	assign cfg_view = ~cfg_on_sync;

	// Reserved bits 7 to 1 read as zero.
	assign tb_view = bcs_pkg::RSVD_READ |
		(bcs_pkg::DATA_W'(tb_drive_reg) << bcs_pkg::TB_DRIVE_BIT);

	// Address bit 0 lands on bit 7 through bit 4 on bit 3, parity on 0.
	assign slot_view = {
		rev_inv(slot_sync.addr_n),
		2'h0,
		~slot_sync.parity_n
	};

	// Read data selection.
	wire [bcs_pkg::DATA_W-1:0] rd_mux;

	assign rd_mux =
		sel.cfg_switch ? cfg_view :
		sel.time_base ? tb_view :
		sel.slot_addr ? slot_view :
		bcs_pkg::RSVD_READ;

	// Read data stand for exactly the cycle after the strobe.
	logic [bcs_pkg::DATA_W-1:0] rdata_reg;
	logic [bcs_pkg::DATA_W-1:0] rdata_next;
	logic rd_valid_reg;
	logic rd_valid_next;
	logic unmapped_reg;
	logic unmapped_next;

	assign rdata_next = rd_any ? rd_mux : bcs_pkg::RDATA_RESET;
	assign rd_valid_next = rd_any;
	assign unmapped_next = access_miss;

	// Registers.
	always_ff @(posedge i_ref_clk) begin
		if (!i_nrst) begin
			tb_drive_reg <= bcs_pkg::TB_DRIVE_RESET;
			tb_gate_reg <= bcs_pkg::TB_DRIVE_RESET;
		end else begin
			tb_drive_reg <= tb_drive_next;
			tb_gate_reg <= tb_gate_next;
		end
	end

	always_ff @(posedge i_ref_clk) begin
		if (!i_nrst) begin
			rdata_reg <= bcs_pkg::RDATA_RESET;
			rd_valid_reg <= 1'h0;
			unmapped_reg <= 1'h0;
		end else begin
			rdata_reg <= rdata_next;
			rd_valid_reg <= rd_valid_next;
			unmapped_reg <= unmapped_next;
		end
	end

	// Outputs.
	assign o_rdata = rdata_reg;
	assign o_rd_valid = rd_valid_reg;
	assign o_unmapped = unmapped_reg;
	assign o_processor_time_base_gate = tb_gate_reg;

endmodule : bcs_board_cfg_regs
`default_nettype wire

// ---- bcs_board_cfg_regs_tb.sv ----
// Self-checking bench for the board configuration register bank.
`timescale 1ns/1ns
`default_nettype none
module bcs_board_cfg_regs_tb;
	typedef struct packed {
		logic [31:0] a;
		logic [7:0] sw;
		logic [5:0] sl;
		logic [7:0] exp;
	} bcs_row_t;
	logic i_ref_clk = 1'b0;
	logic i_nrst = 1'b0;
	logic [31:0] i_addr = 32'h0;
	logic [7:0] i_wdata = 8'h00;
	logic i_wr = 1'b0;
	logic i_rd = 1'b0;
	logic [7:0] i_cfg_switch_on = 8'h00;
	logic [5:0] slot_n = 6'h3f;
	wire logic [7:0] o_rdata;
	wire logic o_rd_valid;
	wire logic o_unmapped;
	wire logic o_processor_time_base_gate;
	wire logic i_slot_addr_bit0_n = slot_n[5];
	wire logic i_slot_addr_bit1_n = slot_n[4];
	wire logic i_slot_addr_bit2_n = slot_n[3];
	wire logic i_slot_addr_bit3_n = slot_n[2];
	wire logic i_slot_addr_bit4_n = slot_n[1];
	wire logic i_slot_addr_parity_n = slot_n[0];
	int bad_count = 0;
	int comparisons = 0;
	int cycles = 0;
	bcs_row_t rows [9] = '{'{32'h6, 8'h00, 6'h3f, 8'h01},
		'{32'h5, 8'h00, 6'h3f, 8'hff}, '{32'h5, 8'hff, 6'h3f, 8'h00},
		'{32'h5, 8'ha5, 6'h3f, 8'h5a}, '{32'hff10_0007, 8'h00, 6'h3f, 8'h00},
		'{32'hff10_0007, 8'h00, 6'h01, 8'hf8},
		'{32'hff10_0007, 8'h00, 6'h1e, 8'h81},
		'{32'hff10_0007, 8'h00, 6'h2e, 8'h41}, '{32'h4, 8'h00, 6'h00, 8'h00}};

	bcs_board_cfg_regs DUT (.*);

	initial begin
		forever #5 i_ref_clk = ~i_ref_clk;
	end

	task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
		comparisons++;
		if (seen !== exp) begin
			bad_count++;
			$display("[ERR] %0t seen %h expected %h", $time, seen, exp);
		end
	endtask : chk

	task automatic rd(input logic [31:0] a, input logic [7:0] exp);
		logic miss;
		miss = !(a inside {32'h5, 32'h6, 32'hff10_0007});
		@(posedge i_ref_clk);
		i_addr <= a;
		i_rd <= 1'b1;
		@(posedge i_ref_clk);
		i_rd <= 1'b0;
		#1;
		chk(o_rdata, exp);
		chk({6'h00, o_rd_valid, o_unmapped}, {6'h00, 1'b1, miss});
	endtask : rd

	// Writes one byte, then checks the gate pin after the write edge.
	task automatic wr(input logic [31:0] a, input logic [7:0] d, input logic g);
		logic miss;
		miss = !(a inside {32'h5, 32'h6, 32'hff10_0007});
		@(posedge i_ref_clk);
		i_addr <= a;
		i_wdata <= d;
		i_wr <= 1'b1;
		@(posedge i_ref_clk);
		i_wr <= 1'b0;
		#1;
		chk({7'h00, o_processor_time_base_gate}, {7'h00, g});
		chk({6'h00, o_rd_valid, o_unmapped}, {6'h00, 1'b0, miss});
	endtask : wr

	task automatic end_of_test();
		$display("comparisons %0d mismatches %0d", comparisons, bad_count);
		if (bad_count == 0 && comparisons > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask : end_of_test

	always @(posedge i_ref_clk) begin
		cycles++;
		if (cycles == 1000) begin
			bad_count++;
			end_of_test();
		end
	end

	initial begin
		repeat (12) @(posedge i_ref_clk);
		i_nrst <= 1'b1;
		@(posedge i_ref_clk);
		#1;
		chk({7'h00, o_processor_time_base_gate}, 8'h01);
		chk(o_rdata, 8'h00);
		chk({6'h00, o_rd_valid, o_unmapped}, 8'h00);
		foreach (rows[k]) begin
			@(posedge i_ref_clk);
			i_cfg_switch_on <= rows[k].sw;
			slot_n <= rows[k].sl;
			repeat (6) @(posedge i_ref_clk);
			rd(rows[k].a, rows[k].exp);
		end
		wr(32'h6, 8'hfe, 1'b0);
		rd(32'h6, 8'h00);
		wr(32'h5, 8'hff, 1'b0);
		wr(32'hff10_0007, 8'hff, 1'b0);
		wr(32'h4, 8'hff, 1'b0);
		wr(32'h6, 8'hff, 1'b1);
		rd(32'h6, 8'h01);
		// Back-to-back write then read; the read must see the new bit.
		@(posedge i_ref_clk);
		i_addr <= 32'h6;
		i_wdata <= 8'hfe;
		i_wr <= 1'b1;
		@(posedge i_ref_clk);
		i_wr <= 1'b0;
		i_rd <= 1'b1;
		@(posedge i_ref_clk);
		i_rd <= 1'b0;
		#1;
		chk(o_rdata, 8'h00);
		chk({7'h00, o_processor_time_base_gate}, 8'h00);
		@(posedge i_ref_clk);
		#1;
		chk(o_rdata, 8'h00);
		chk({6'h00, o_rd_valid, o_unmapped}, 8'h00);
		wr(32'h6, 8'h00, 1'b0);
		@(posedge i_ref_clk);
		i_nrst <= 1'b0;
		repeat (4) @(posedge i_ref_clk);
		i_nrst <= 1'b1;
		@(posedge i_ref_clk);
		#1;
		chk({7'h00, o_processor_time_base_gate}, 8'h01);
		chk(o_rdata, 8'h00);
		chk({6'h00, o_rd_valid, o_unmapped}, 8'h00);
		rd(32'h6, 8'h01);
		end_of_test();
	end
endmodule : bcs_board_cfg_regs_tb
`default_nettype wire

// ---- bcs_pin_sync.sv ----
// Three-stage input synchroniser with an agreement filter on the last two.
`timescale 1ns/1ns
`default_nettype none
module bcs_pin_sync #(
	parameter int unsigned WIDTH = 1
) (
	// Clock and reset.
	input wire logic i_ref_clk,
	input wire logic i_nrst,
	// Asynchronous levels in, filtered levels out.
	input wire logic [WIDTH-1:0] i_async,
	output logic [WIDTH-1:0] o_level
);

	logic [WIDTH-1:0] meta_reg;
	logic [WIDTH-1:0] stage2_reg;
	logic [WIDTH-1:0] stage3_reg;
	logic [WIDTH-1:0] level_reg;
	logic [WIDTH-1:0] level_next;
	logic [WIDTH-1:0] agree;

	if (WIDTH < 1) begin : g_chk
		$error("bcs_pin_sync needs WIDTH of at least one");
	end

	// A bit only moves once the second and third stages agree.
	assign agree = ~(stage2_reg ^ stage3_reg);
	assign level_next = (agree & stage3_reg) | (~agree & level_reg);
	assign o_level = level_reg;

	always_ff @(posedge i_ref_clk) begin
		if (!i_nrst) begin
			meta_reg <= '0;
			stage2_reg <= '0;
			stage3_reg <= '0;
			level_reg <= '0;
		end else begin
			meta_reg <= i_async;
			stage2_reg <= meta_reg;
			stage3_reg <= stage2_reg;
			level_reg <= level_next;
		end
	end

endmodule : bcs_pin_sync
`default_nettype wire

// ---- bcs_pkg.sv ----
// Shared constants and carrier types for the board configuration register bank.
package bcs_pkg;

	// Bus and field widths.
	localparam int unsigned ADDR_W = 32;
	localparam int unsigned DATA_W = 8;
	localparam int unsigned CFG_W = 8;
	localparam int unsigned SLOT_W = 5;
	localparam int unsigned SYNC_STAGES = 3;

	// Register offsets on the local bus.
	localparam logic [ADDR_W-1:0] OFS_CFG_SWITCH = 32'h0000_0005;
	localparam logic [ADDR_W-1:0] OFS_TIME_BASE = 32'h0000_0006;
	localparam logic [ADDR_W-1:0] OFS_SLOT_ADDR = 32'hff10_0007;

	// Field positions.
	localparam int unsigned TB_DRIVE_BIT = 0;
	localparam int unsigned SLOT_ADDR_MSB = 7;
	localparam int unsigned SLOT_ADDR_LSB = 3;
	localparam int unsigned SLOT_PARITY_BIT = 0;

	// Reset values.
	localparam logic TB_DRIVE_RESET = 1'h1;
	localparam logic [DATA_W-1:0] RDATA_RESET = 8'h00;
	localparam logic [DATA_W-1:0] RSVD_READ = 8'h00;

	// One bus request as seen by the register bank.
	typedef struct packed {
		logic [ADDR_W-1:0] addr;
		logic [DATA_W-1:0] wdata;
		logic wr;
		logic rd;
	} bcs_bus_req_t;

	// Backplane slot address pins, all active low.
	typedef struct packed {
		logic [SLOT_W-1:0] addr_n;
		logic parity_n;
	} bcs_slot_pins_t;

	// Address decode result.
	typedef struct packed {
		logic cfg_switch;
		logic time_base;
		logic slot_addr;
		logic hit;
	} bcs_sel_t;

endpackage : bcs_pkg

// ---- bcs_regs_props.sv ----
// Concurrent checks and covers for the board configuration register bank.
`timescale 1ns/1ns
`default_nettype none
module bcs_regs_props (
	// Clock and reset.
	input wire logic i_ref_clk,
	input wire logic i_nrst,
	// Register port.
	input wire logic [31:0] i_addr,
	input wire logic [7:0] i_wdata,
	input wire logic i_wr,
	input wire logic i_rd,
	input wire logic [7:0] o_rdata,
	input wire logic o_rd_valid,
	input wire logic o_unmapped,
	// Pins.
	input wire logic [7:0] i_cfg_switch_on,
	input wire logic i_slot_addr_bit0_n,
	input wire logic i_slot_addr_bit1_n,
	input wire logic i_slot_addr_bit2_n,
	input wire logic i_slot_addr_bit3_n,
	input wire logic i_slot_addr_bit4_n,
	input wire logic i_slot_addr_parity_n,
	input wire logic o_processor_time_base_gate
);
	logic [2:0] quiet_reg;
	logic [13:0] pins_reg;
	wire logic [13:0] pins = {i_cfg_switch_on, i_slot_addr_bit0_n,
		i_slot_addr_bit1_n, i_slot_addr_bit2_n, i_slot_addr_bit3_n,
		i_slot_addr_bit4_n, i_slot_addr_parity_n};
	wire logic [7:0] slot_exp = {~pins[5:1], 2'h0, ~pins[0]};
	// Pin reads are only judged once the synchroniser has settled.
	wire logic settled = quiet_reg > 3'h5;
	wire logic rd_slot = i_rd && i_addr == 32'hff10_0007;
	always_ff @(posedge i_ref_clk) begin
		pins_reg <= pins;
		if (!i_nrst || pins != pins_reg) begin
			quiet_reg <= 3'h0;
		end else if (quiet_reg != 3'h7) begin
			quiet_reg <= quiet_reg + 3'h1;
		end
	end
	default clocking @(posedge i_ref_clk); endclocking
	default disable iff (!i_nrst);
	sw_read_a: assert property (i_rd && i_addr == 32'h5 && settled
		|=> o_rdata == ~$past(i_cfg_switch_on)) else $error("switch read");
	gate_write_a: assert property (i_wr && i_addr == 32'h6
		|=> o_processor_time_base_gate == $past(i_wdata[0]))
		else $error("gate write");
	tb_read_a: assert property (i_rd && i_addr == 32'h6
		|=> o_rd_valid && o_rdata == {7'h00, o_processor_time_base_gate})
		else $error("time base read");
	slot_read_a: assert property (rd_slot && settled
		|=> o_rdata == $past(slot_exp)) else $error("slot read");
	slot_rsvd_a: assert property (rd_slot |=> o_rdata[2:1] == 2'h0)
		else $error("slot reserved bits");
	ro_write_a: assert property (i_wr && i_addr != 32'h6
		|=> $stable(o_processor_time_base_gate)) else $error("ro write");
	unmap_read_a: assert property (i_rd &&
		!(i_addr inside {32'h5, 32'h6, 32'hff10_0007})
		|=> o_unmapped && o_rd_valid && o_rdata == 8'h00)
		else $error("unmapped read");
	cover property (i_wr && i_addr == 32'h6 && !i_wdata[0]);
	cover property (rd_slot && settled);
	cover property (o_unmapped);
	cover property (i_wr && i_addr == 32'h6 ##1 i_rd && i_addr == 32'h6);
endmodule : bcs_regs_props
bind bcs_board_cfg_regs bcs_regs_props u_props (.*);
`default_nettype wire
